// ==== hdl/mas_core.sv ====
// Purpose: program counter, ROM addressing, RAM pointers, stack and table counter
// Assumes: decoder issues one command per enabled cycle, flags held outside
// Notes: RAM is an internal nibble array; every command completes in one cycle
`timescale 1ns/1ps
`include "mas_map.svh"
module mas_core #(
  parameter bit SMALL_VARIANT = 1'b0  // 1: 2048-byte ROM, 128-nibble RAM
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  // decoder command
  input  wire logic              cmd_valid,
  input  wire mas_pkg::mas_cmd_t cmd,
  input  wire logic [1:0]        cmd_len,
  input  wire logic [11:0]       cmd_target,
  input  wire logic [7:0]        cmd_ram_addr,
  input  wire logic              cmd_use_imm,
  input  wire logic [3:0]        cmd_data,
  input  wire logic [3:0]        cmd_short_n,
  input  wire mas_pkg::mas_src_t cmd_src,
  // flags from the datapath
  input  wire logic [3:0]        flags_in,
  input  wire logic              carry_flag,
  // ROM programming
  input  wire logic              rom_prog_en,
  input  wire logic [11:0]       rom_prog_addr,
  input  wire logic [7:0]        rom_prog_data,
  // fetch results
  output logic      [11:0]       pc_out,
  output logic      [7:0]        instr_out,
  output logic                   instr_valid,
  // accumulator load
  output logic      [3:0]        acc_data,
  output logic                   acc_load,
  // flag restore
  output logic      [3:0]        flags_out,
  output logic                   flags_load,
  // pattern output ports
  output logic      [3:0]        output_port_two,
  output logic      [3:0]        output_port_one,
  output logic                   port_out_strobe,
  // pointers and address buffer
  output logic      [3:0]        page_pointer,
  output logic      [3:0]        word_pointer,
  output logic      [7:0]        ram_address_buffer,
  output logic      [3:0]        port_bit_sel,
  output logic                   port_bit_strobe
);
  // state
  logic [11:0] pc_r;          // next fetch address
  logic [11:0] pc_nxt;
  logic [7:0]  instr_r;       // fetched byte
  logic        instr_vld_r;   // fetch pulse
  logic [3:0]  acc_r;         // accumulator data
  logic        acc_ld_r;      // accumulator load pulse
  logic [3:0]  flg_r;         // restored flags
  logic        flg_ld_r;      // flag restore pulse
  logic [3:0]  p2_r;          // upper pattern nibble
  logic [3:0]  p1_r;          // lower pattern nibble
  logic        pstb_r;        // pattern strobe
  logic [3:0]  page_r;        // page pointer
  logic [3:0]  word_r;        // word pointer
  logic [7:0]  raa_r;         // RAM address buffer
  logic [3:0]  bit_r;         // selected port bit
  logic        bstb_r;        // port bit strobe
  logic [3:0]  ram [0:255];   // data memory, own space

  // command decode
  wire         go        = clk_en & cmd_valid;
  wire         is_fetch  = go & (cmd == mas_pkg::MAS_CMD_FETCH);
  wire         is_jump   = go & (cmd == mas_pkg::MAS_CMD_JUMP);
  wire         is_pbr    = go & (cmd == mas_pkg::MAS_CMD_PAGE_BRANCH);
  wire         is_call   = go & (cmd == mas_pkg::MAS_CMD_CALL);
  wire         is_scall  = go & (cmd == mas_pkg::MAS_CMD_SHORT_CALL);
  wire         is_intr   = go & (cmd == mas_pkg::MAS_CMD_INTR);
  wire         is_ret    = go & (cmd == mas_pkg::MAS_CMD_RET);
  wire         is_interrupt_return   = go & (cmd == mas_pkg::MAS_CMD_INTERRUPT_RETURN);
  wire         is_thi    = go & (cmd == mas_pkg::MAS_CMD_TBL_HIGH);
  wire         is_tlo    = go & (cmd == mas_pkg::MAS_CMD_TBL_LOW);
  wire         is_pat    = go & (cmd == mas_pkg::MAS_CMD_PATTERN);
  wire         is_rd     = go & (cmd == mas_pkg::MAS_CMD_RAM_READ);
  wire         is_wr     = go & (cmd == mas_pkg::MAS_CMD_RAM_WRITE);
  wire         is_spage  = go & (cmd == mas_pkg::MAS_CMD_SET_PAGE);
  wire         is_sword  = go & (cmd == mas_pkg::MAS_CMD_SET_WORD);
  wire         is_pbit   = go & (cmd == mas_pkg::MAS_CMD_PORT_BIT);
  wire         is_save   = is_call | is_scall | is_intr;
  wire         is_rest   = is_ret | is_interrupt_return;

  // RAM addressing
  // small part does not decode the buffer MSB
  wire  [7:0]  ram_mask  = SMALL_VARIANT ? 8'h7f : 8'hff;
  // buffer loads from pointers or from the immediate address
  wire  [7:0]  raa_src   = cmd_use_imm ? cmd_ram_addr : {page_r, word_r};
  wire         raa_load  = is_rd | is_wr | is_pat;
  wire  [7:0]  raa_nxt   = raa_load ? raa_src : raa_r;
  // data access uses the buffer value of this command
  wire  [7:0]  ram_loc   = raa_nxt & ram_mask;

  // stack addressing
  wire  [3:0]  level     = ram[`MAS_RAM_LEVEL & ram_mask];
  wire  [3:0]  level_dec = level - 4'h1;
  wire  [3:0]  level_inc = level + 4'h1;
  // save uses the current level, restore the incremented one
  wire  [3:0]  stk_lvl   = is_rest ? level_inc : level;
  wire  [7:0]  stk_base  = {`MAS_STACK_PREFIX, stk_lvl, `MAS_STACK_SUFFIX};
  wire  [7:0]  stk_a0    = (stk_base | 8'h00) & ram_mask;
  wire  [7:0]  stk_a1    = (stk_base | 8'h01) & ram_mask;
  wire  [7:0]  stk_a2    = (stk_base | 8'h02) & ram_mask;
  wire  [7:0]  stk_a3    = (stk_base | 8'h03) & ram_mask;
  // restored counter and flags, same nibble order as the save
  wire  [11:0] pop_pc    = {ram[stk_a2], ram[stk_a1], ram[stk_a0]};
  wire  [3:0]  pop_flags = ram[stk_a3];

  // table counter
  wire  [11:0] tc_val    = {ram[`MAS_RAM_TC_HIGH & ram_mask],
                            ram[`MAS_RAM_TC_MID & ram_mask],
                            ram[`MAS_RAM_TC_LOW & ram_mask]};
  wire  [11:0] tc_inc    = tc_val + 12'h001;

  // vectors and call targets
  wire  [11:0] src_vec   =
      (cmd_src == mas_pkg::MAS_SRC_EXT_ONE)  ? `MAS_VEC_EXT_ONE  :
      (cmd_src == mas_pkg::MAS_SRC_SERIAL)   ? `MAS_VEC_SERIAL   :
      (cmd_src == mas_pkg::MAS_SRC_TMR_ONE)  ? `MAS_VEC_TMR_ONE  :
      (cmd_src == mas_pkg::MAS_SRC_TMR_TWO)  ? `MAS_VEC_TMR_TWO  :
      (cmd_src == mas_pkg::MAS_SRC_INTERVAL) ? `MAS_VEC_INTERVAL :
                                               `MAS_VEC_EXT_TWO;
  // 8n + 6 for n of 1 to 15
  wire  [11:0] scall_tgt = {5'h00, cmd_short_n, 3'h0} + `MAS_SHORT_CALL_BASE;
  // pc_r already points past the branch, so its page field is the
  // next page when the branch sat in the last word of a page
  wire  [11:0] pbr_tgt   = {pc_r[`MAS_PC_PAGE_MSB:`MAS_PC_PAGE_LSB],
                            cmd_target[5:0]};

  // ROM addressing
  // pattern address: top 32 words, carry then the pointed nibble
  wire  [11:0] pat_addr  = {`MAS_PATTERN_BASE, carry_flag, ram[ram_loc]};
  wire  [11:0] rom_sel   = (is_thi | is_tlo) ? tc_val :
                           is_pat            ? pat_addr :
                                               pc_r;
  // small part does not decode the counter MSB
  wire  [11:0] rom_addr  = SMALL_VARIANT ? {1'b0, rom_sel[10:0]} : rom_sel;
  wire  [11:0] rom_pa    = SMALL_VARIANT ? {1'b0, rom_prog_addr[10:0]} : rom_prog_addr;
  wire  [7:0]  rom_data;

  // program ROM, separate from the RAM array
  mas_rom u_rom (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .clk_en    (clk_en),
    .prog_en   (rom_prog_en),
    .prog_addr (rom_pa),
    .prog_data (rom_prog_data),
    .rd_addr   (rom_addr),
    .rd_data   (rom_data)
  );

  // next program counter
  always_comb begin
    pc_nxt = pc_r;
    if (is_fetch) begin
      pc_nxt = pc_r + {10'h000, cmd_len};     // advance by length
    end else if (is_jump || is_call) begin
      pc_nxt = cmd_target;                    // full load
    end else if (is_pbr) begin
      pc_nxt = pbr_tgt;                       // within-page load
    end else if (is_scall) begin
      pc_nxt = scall_tgt;                     // short call entry
    end else if (is_intr) begin
      pc_nxt = src_vec;                       // vector entry
    end else if (is_rest) begin
      pc_nxt = pop_pc;                        // return address
    end
  end

  // counter and fetch register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_r        <= `MAS_PC_RESET;
      instr_r     <= 8'h00;
      instr_vld_r <= 1'b0;
    end else if (clk_en) begin
      pc_r        <= pc_nxt;
      instr_r     <= is_fetch ? rom_data : instr_r;
      instr_vld_r <= is_fetch;
    end
  end

  // accumulator and flag results
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r    <= 4'h0;
      acc_ld_r <= 1'b0;
      flg_r    <= 4'h0;
      flg_ld_r <= 1'b0;
    end else if (clk_en) begin
      // table read picks a half, RAM read gives the nibble
      if (is_thi) begin
        acc_r <= rom_data[7:4];
      end else if (is_tlo) begin
        acc_r <= rom_data[3:0];
      end else if (is_rd) begin
        acc_r <= ram[ram_loc];
      end
      acc_ld_r <= is_thi | is_tlo | is_rd;
      flg_r    <= is_interrupt_return ? pop_flags : flg_r;
      flg_ld_r <= is_interrupt_return;
    end
  end

  // pattern output
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      p2_r   <= 4'h0;
      p1_r   <= 4'h0;
      pstb_r <= 1'b0;
    end else if (clk_en) begin
      if (is_pat) begin
        p2_r <= rom_data[7:4];
        p1_r <= rom_data[3:0];
      end
      pstb_r <= is_pat;
    end
  end

  // pointers, buffer, port bit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      page_r <= `MAS_PTR_RESET;
      word_r <= `MAS_PTR_RESET;
      raa_r  <= 8'h00;
      bit_r  <= 4'h0;
      bstb_r <= 1'b0;
    end else if (clk_en) begin
      page_r <= is_spage ? cmd_data : page_r;
      word_r <= is_sword ? cmd_data : word_r;
      raa_r  <= raa_nxt;
      bit_r  <= is_pbit ? word_r : bit_r;
      bstb_r <= is_pbit;
    end
  end

  // data memory writes
  // no reset: level word and table counter start undefined,
  // software must set the level before the first call
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      if (is_wr) begin
        ram[ram_loc] <= cmd_data;
      end
      if (is_save) begin
        // nibble order: pc low, pc mid, pc high, flags
        ram[stk_a0] <= pc_r[3:0];
        ram[stk_a1] <= pc_r[7:4];
        ram[stk_a2] <= pc_r[11:8];
        ram[stk_a3] <= flags_in;
        ram[`MAS_RAM_LEVEL & ram_mask] <= level_dec;
      end
      if (is_rest) begin
        ram[`MAS_RAM_LEVEL & ram_mask] <= level_inc;
      end
      if (is_thi) begin
        // post-increment of the table counter after the high read
        ram[`MAS_RAM_TC_LOW & ram_mask]  <= tc_inc[3:0];
        ram[`MAS_RAM_TC_MID & ram_mask]  <= tc_inc[7:4];
        ram[`MAS_RAM_TC_HIGH & ram_mask] <= tc_inc[11:8];
      end
    end
  end

  // outputs
  assign pc_out             = pc_r;
  assign instr_out          = instr_r;
  assign instr_valid        = instr_vld_r;
  assign acc_data           = acc_r;
  assign acc_load           = acc_ld_r;
  assign flags_out          = flg_r;
  assign flags_load         = flg_ld_r;
  assign output_port_two    = p2_r;
  assign output_port_one    = p1_r;
  assign port_out_strobe    = pstb_r;
  assign page_pointer       = page_r;
  assign word_pointer       = word_r;
  assign ram_address_buffer = raa_r;
  assign port_bit_sel       = bit_r;
  assign port_bit_strobe    = bstb_r;
endmodule : mas_core

// ==== hdl/mas_map.svh ====
// Purpose: offsets, field positions and fixed addresses of the addressing core
// Assumes: included by bare name; definitions only
// Notes: RAM addresses are nibble addresses, ROM addresses are byte addresses
// Contract
// - twelve bit counter: advance, load, clear
// - upper six bits page, lower six word
// - fetch from counter address
// - table reads copy high/low nibble to accumulator
// - pattern address from pointed nibble plus carry
// - ROM and RAM spaces kept separate
// - start at address zero after reset
// - fixed vector per interrupt source
// - short call target is 8n+6
// - pattern table is top 32 ROM words
// - small ROM ignores counter MSB, aliases
// - unprogrammed ROM words read zero
// - page and word pointers, four bits each
// - RAM pages of sixteen nibbles
// - word pointer selects port bit
// - address buffer from pointers or immediate
// - RAM access at buffer address
// - small RAM ignores buffer MSB, aliases
// - four nibbles per stack level, save/restore
// - level decrements after save, increments before restore
// - level word at FF, address 11,level,00
// - table counter in RAM FC, FD, FE
// - last-word page branch lands next page
`ifndef MAS_MAP_SVH
`define MAS_MAP_SVH
// program counter fields
`define MAS_PC_PAGE_MSB   11
`define MAS_PC_PAGE_LSB   6
`define MAS_PC_RESET      12'h000
// interrupt vectors
`define MAS_VEC_EXT_ONE   12'h002
`define MAS_VEC_SERIAL    12'h004
`define MAS_VEC_TMR_ONE   12'h006
`define MAS_VEC_TMR_TWO   12'h008
`define MAS_VEC_INTERVAL  12'h00a
`define MAS_VEC_EXT_TWO   12'h00c
// short call base: target = 8n + base
`define MAS_SHORT_CALL_BASE 12'h006
// pattern table base (top 32 words)
`define MAS_PATTERN_BASE  7'h7f
// RAM map of the table counter and the level word
`define MAS_RAM_TC_LOW    8'hfc
`define MAS_RAM_TC_MID    8'hfd
`define MAS_RAM_TC_HIGH   8'hfe
`define MAS_RAM_LEVEL     8'hff
// stack address prefix and suffix
`define MAS_STACK_PREFIX  2'b11
`define MAS_STACK_SUFFIX  2'b00
// pointer reset values
`define MAS_PTR_RESET     4'h0
`endif

// ==== hdl/mas_pkg.sv ====
// Purpose: types shared by the addressing core
// Assumes: nothing
// Notes: command codes are issued by the instruction decoder
package mas_pkg;
  // decoder commands
  typedef enum logic [4:0] {
    MAS_CMD_NOP,
    MAS_CMD_FETCH,
    MAS_CMD_JUMP,
    MAS_CMD_PAGE_BRANCH,
    MAS_CMD_CALL,
    MAS_CMD_SHORT_CALL,
    MAS_CMD_INTR,
    MAS_CMD_RET,
    MAS_CMD_INTERRUPT_RETURN,
    MAS_CMD_TBL_HIGH,
    MAS_CMD_TBL_LOW,
    MAS_CMD_PATTERN,
    MAS_CMD_RAM_READ,
    MAS_CMD_RAM_WRITE,
    MAS_CMD_SET_PAGE,
    MAS_CMD_SET_WORD,
    MAS_CMD_PORT_BIT
  } mas_cmd_t;
  // interrupt sources
  typedef enum logic [2:0] {
    MAS_SRC_EXT_ONE,
    MAS_SRC_SERIAL,
    MAS_SRC_TMR_ONE,
    MAS_SRC_TMR_TWO,
    MAS_SRC_INTERVAL,
    MAS_SRC_EXT_TWO
  } mas_src_t;
endpackage : mas_pkg

// ==== hdl/mas_rom.sv ====
// Purpose: program ROM with per-word programmed marks
// Assumes: loaded through the programming port before use
// Notes: combinational read; words never programmed read as zero
`timescale 1ns/1ps
module mas_rom (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  // programming port
  input  wire logic        prog_en,
  input  wire logic [11:0] prog_addr,
  input  wire logic [7:0]  prog_data,
  // read port
  input  wire logic [11:0] rd_addr,
  output logic      [7:0]  rd_data
);
  logic [7:0]    mem [0:4095];  // byte storage
  logic [4095:0] written_r;     // programmed marks

  // storage write, no reset on the array
  always_ff @(posedge sys_clk) begin
    if (clk_en && prog_en) begin
      mem[prog_addr] <= prog_data;
    end
  end
  // marks cleared at reset, set on programming
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      written_r <= '0;
    end else if (clk_en && prog_en) begin
      written_r[prog_addr] <= 1'b1;
    end
  end

  // unprogrammed words give the no-operation code
  assign rd_data = written_r[rd_addr] ? mem[rd_addr] : 8'h00;
endmodule : mas_rom

// ==== verif/mas_core_chk.sv ====
// Purpose: temporal checks on the ports of the addressing core
// Assumes: bound to every mas_core instance; one clock, async active-low reset
// Notes: results are due at the next clock edge after the command is taken, enabled or not
`timescale 1ns/1ps
module mas_core_chk #(
  parameter bit SMALL_VARIANT = 1'b0  // mirrors the core variant
) (
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              rst_n,
  // command side
  input wire logic              clk_en,
  input wire logic              cmd_valid,
  input wire mas_pkg::mas_cmd_t cmd,
  input wire logic [1:0]        cmd_len,
  input wire logic [11:0]       cmd_target,
  input wire logic [3:0]        cmd_data,
  input wire logic [3:0]        cmd_short_n,
  input wire mas_pkg::mas_src_t cmd_src,
  // observed outputs
  input wire logic [11:0]       pc_out,
  input wire logic              instr_valid,
  input wire logic              acc_load,
  input wire logic              port_out_strobe,
  input wire logic [3:0]        page_pointer,
  input wire logic [3:0]        word_pointer,
  input wire logic [3:0]        port_bit_sel,
  input wire logic              port_bit_strobe
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // commands that may load the accumulator or drive the pattern ports
  wire logic rd_cmd  = cmd_valid && (cmd == mas_pkg::MAS_CMD_TBL_HIGH
                       || cmd == mas_pkg::MAS_CMD_TBL_LOW || cmd == mas_pkg::MAS_CMD_RAM_READ);
  wire logic pat_cmd = cmd_valid && cmd == mas_pkg::MAS_CMD_PATTERN;
  // one command taken at this edge
  sequence s_take(mas_pkg::mas_cmd_t c);
    cmd_valid && clk_en && cmd == c;
  endsequence
  property p_start; $rose(rst_n) |-> pc_out == 12'h000 && !instr_valid; endproperty
  property p_fetch; s_take(mas_pkg::MAS_CMD_FETCH) |=>
    instr_valid && pc_out == $past(pc_out) + {10'h000, $past(cmd_len)}; endproperty
  property p_branch; s_take(mas_pkg::MAS_CMD_PAGE_BRANCH) |=>
    pc_out == {$past(pc_out[11:6]), $past(cmd_target[5:0])}; endproperty
  property p_vector; s_take(mas_pkg::MAS_CMD_INTR) |=>
    pc_out == 12'h002 + {8'h00, $past(cmd_src), 1'b0}; endproperty
  property p_short; s_take(mas_pkg::MAS_CMD_SHORT_CALL) |=>
    pc_out == {5'h00, $past(cmd_short_n), 3'b000} + 12'h006; endproperty
  property p_callret; s_take(mas_pkg::MAS_CMD_CALL) ##1 s_take(mas_pkg::MAS_CMD_RET) |=>
    pc_out == $past(pc_out, 2); endproperty
  property p_page; s_take(mas_pkg::MAS_CMD_SET_PAGE) |=> page_pointer == $past(cmd_data);
  endproperty
  property p_portbit; s_take(mas_pkg::MAS_CMD_PORT_BIT) |=>
    port_bit_strobe && port_bit_sel == $past(word_pointer); endproperty
  property p_accsrc; acc_load && $past(clk_en) |-> $past(rd_cmd); endproperty
  property p_patsrc; port_out_strobe && $past(clk_en) |-> $past(pat_cmd); endproperty
  a_start:   assert property (p_start)   else $error("counter not zero after reset");
  a_fetch:   assert property (p_fetch)   else $error("fetch advance wrong");
  a_branch:  assert property (p_branch)  else $error("page branch target wrong");
  a_vector:  assert property (p_vector)  else $error("interrupt vector wrong");
  a_short:   assert property (p_short)   else $error("short call target wrong");
  a_callret: assert property (p_callret) else $error("return address wrong");
  a_page:    assert property (p_page)    else $error("page pointer not loaded");
  a_portbit: assert property (p_portbit) else $error("port bit select wrong");
  a_accsrc:  assert property (p_accsrc)  else $error("stray accumulator load");
  a_patsrc:  assert property (p_patsrc)  else $error("stray pattern output");
endmodule : mas_core_chk

bind mas_core mas_core_chk #(.SMALL_VARIANT(SMALL_VARIANT)) u_chk (.sys_clk, .rst_n, .clk_en,
  .cmd_valid, .cmd, .cmd_len, .cmd_target, .cmd_data, .cmd_short_n, .cmd_src, .pc_out,
  .instr_valid, .acc_load, .port_out_strobe, .page_pointer, .word_pointer, .port_bit_sel,
  .port_bit_strobe);

// ==== verif/mas_flag_model.sv ====
// Purpose: flag register of the datapath beside the addressing core
// Assumes: bench presents new flags with set_flags
// Notes: carry position is a parameter with a plain default
`timescale 1ns/1ps
module mas_flag_model #(
  parameter int CARRY_BIT = 0  // bit of the flag nibble that holds carry
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       clk_en,
  // bench control
  input  wire logic       set_flags,
  input  wire logic [3:0] set_val,
  // core side
  input  wire logic       flags_load,
  input  wire logic [3:0] flags_out,
  output      logic [3:0] flags_in,
  output      logic       carry_flag
);
  logic [3:0] flags_r;    // held flags
  logic [3:0] flags_nxt;  // next flags
  // restore from the core wins over a bench load
  assign flags_nxt  = flags_load ? flags_out : (set_flags ? set_val : flags_r);
  assign flags_in   = set_flags ? set_val : flags_r;
  assign carry_flag = flags_in[CARRY_BIT];
  // flags change only on enabled edges
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) flags_r <= 4'h0;
    else if (clk_en) flags_r <= flags_nxt;
  end
endmodule : mas_flag_model

// ==== verif/tb_memory_addressing_and_stack.sv ====
// Purpose: self-checking bench for the addressing core
// Assumes: 20 MHz clock, inputs driven on the falling edge
// Notes: driver queues expectations, a monitor checks them after each edge
`timescale 1ns/1ps
module tb_memory_addressing_and_stack;
  logic              sys_clk, rst_n, clk_en, cmd_valid, cmd_use_imm, rom_prog_en;
  mas_pkg::mas_cmd_t cmd;
  mas_pkg::mas_src_t cmd_src;
  logic [1:0]        cmd_len;
  logic [11:0]       cmd_target, rom_prog_addr, pc_out, epc;
  logic [7:0]        cmd_ram_addr, rom_prog_data, instr_out, ram_address_buffer;
  logic [3:0]        cmd_data, cmd_short_n, flags_in, acc_data, flags_out, set_val;
  logic [3:0]        output_port_two, output_port_one, page_pointer, word_pointer, port_bit_sel;
  logic              carry_flag, instr_valid, acc_load, flags_load, port_out_strobe;
  logic              port_bit_strobe, set_flags, tk;
  logic [7:0]        img [4096];      // expected ROM image
  logic [11:0]       pq[$], eq[$];    // counter and result notes
  logic [11:0]       pcs [6];         // saved counters
  logic [3:0]        fl [6];          // saved flags
  logic [31:0]       seed, r;
  int                num_errors, n_tests, i, k;
  mas_core #(.SMALL_VARIANT(1'b0)) dut (.sys_clk, .rst_n, .clk_en, .cmd_valid, .cmd, .cmd_len,
    .cmd_target, .cmd_ram_addr, .cmd_use_imm, .cmd_data, .cmd_short_n, .cmd_src, .flags_in,
    .carry_flag, .rom_prog_en, .rom_prog_addr, .rom_prog_data, .pc_out, .instr_out, .instr_valid,
    .acc_data, .acc_load, .flags_out, .flags_load, .output_port_two, .output_port_one,
    .port_out_strobe, .page_pointer, .word_pointer, .ram_address_buffer, .port_bit_sel,
    .port_bit_strobe);
  mas_flag_model u_flags (.sys_clk, .rst_n, .clk_en, .set_flags, .set_val, .flags_load,
    .flags_out, .flags_in, .carry_flag);
  // compare and count
  task chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // xorshift step
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  // one command, noting the next counter value
  task run(input mas_pkg::mas_cmd_t c, input logic [11:0] p);
    cmd = c;
    cmd_valid = 1'b1;
    pq.push_back(p);
    epc = p;
    @(negedge sys_clk);
  endtask : run
  // one random ROM byte through the load port
  task prog(input logic [11:0] a);
    r = xs();
    rom_prog_addr = a;
    rom_prog_data = r[7:0];
    rom_prog_en = 1'b1;
    img[a] = r[7:0];
    @(negedge sys_clk);
  endtask : prog
  // RAM nibble write at an immediate address
  task wr(input logic [7:0] a, input logic [3:0] d);
    cmd_use_imm = 1'b1;
    cmd_ram_addr = a;
    cmd_data = d;
    run(mas_pkg::MAS_CMD_RAM_WRITE, epc);
  endtask : wr
  // RAM nibble read at an immediate address
  task rd(input logic [7:0] a, input logic [3:0] d);
    cmd_use_imm = 1'b1;
    cmd_ram_addr = a;
    eq.push_back({8'h00, d});
    run(mas_pkg::MAS_CMD_RAM_READ, epc);
  endtask : rd
  // counts, verdict, end of run
  task results();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // monitor: counter after each taken command, value on each result pulse
  always @(posedge sys_clk) begin
    tk = cmd_valid && clk_en && rst_n;
    #1;
    if (tk) begin
      chk(pc_out, pq.pop_front());
      if (instr_valid) chk({4'h0, instr_out}, eq.pop_front());
      if (acc_load) chk({8'h00, acc_data}, eq.pop_front());
      if (port_out_strobe) chk({4'h0, output_port_two, output_port_one}, eq.pop_front());
      if (flags_load) chk({8'h00, flags_out}, eq.pop_front());
      if (port_bit_strobe) chk({8'h00, port_bit_sel}, eq.pop_front());
    end
  end
  // watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    $display("[FAIL] %0t run did not finish", $time);
    results();
  end
  // main sequence
  initial begin
    foreach (img[j]) img[j] = 8'h00;
    {rst_n, cmd_valid, cmd_use_imm, rom_prog_en, set_flags, set_val} = '0;
    {cmd_target, rom_prog_addr, cmd_ram_addr, rom_prog_data, cmd_data, cmd_short_n} = '0;
    clk_en = 1'b1;
    cmd = mas_pkg::MAS_CMD_NOP;
    cmd_src = mas_pkg::MAS_SRC_EXT_ONE;
    cmd_len = 2'd1;
    seed = 32'hfe73;
    epc = 12'h000;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    chk(pc_out, 12'h000);
    for (i = 0; i < 320; i++) prog(12'(i));
    for (i = 12'hfe0; i < 4096; i++) prog(12'(i));
    rom_prog_en = 1'b0;
    $display("rom load done");
    wr(8'h00, ~img[0][3:0]);
    run(mas_pkg::MAS_CMD_JUMP, 12'h000);
    for (k = 0; k < 8; k++) begin
      cmd_len = {1'b0, k[0]} + 2'd1;
      eq.push_back({4'h0, img[epc]});
      run(mas_pkg::MAS_CMD_FETCH, epc + {10'h000, cmd_len});
    end
    cmd_len = 2'd1;
    cmd_target = 12'h03f;
    run(mas_pkg::MAS_CMD_JUMP, 12'h03f);
    eq.push_back({4'h0, img[12'h03f]});
    run(mas_pkg::MAS_CMD_FETCH, 12'h040);
    cmd_target = 12'h015;
    run(mas_pkg::MAS_CMD_PAGE_BRANCH, 12'h055);
    cmd_target = 12'h200;
    run(mas_pkg::MAS_CMD_JUMP, 12'h200);
    eq.push_back(12'h000);
    run(mas_pkg::MAS_CMD_FETCH, 12'h201);
    $display("fetch and branch done");
    wr(8'hff, 4'hc);
    for (k = 0; k < 6; k++) begin
      r = xs();
      set_val = r[3:0];
      set_flags = 1'b1;
      fl[k] = r[3:0];
      pcs[k] = epc;
      cmd_src = mas_pkg::mas_src_t'(k);
      run(mas_pkg::MAS_CMD_INTR, 12'h002 + 12'(2 * k));
    end
    set_flags = 1'b0;
    rd(8'hff, 4'h6);
    rd(8'hdc, pcs[5][3:0]);
    rd(8'hdd, pcs[5][7:4]);
    rd(8'hde, pcs[5][11:8]);
    rd(8'hdf, fl[5]);
    for (k = 5; k >= 0; k--) begin
      eq.push_back({8'h00, fl[k]});
      run(mas_pkg::MAS_CMD_INTERRUPT_RETURN, pcs[k]);
    end
    rd(8'hff, 4'hc);
    $display("interrupt nesting done");
    for (k = 1; k < 16; k++) begin
      cmd_short_n = k[3:0];
      pcs[0] = epc;
      run(mas_pkg::MAS_CMD_SHORT_CALL, 12'(8 * k + 6));
      if (k == 8) begin
        clk_en = 1'b0;
        repeat (2) @(negedge sys_clk);
        clk_en = 1'b1;
      end
      run(mas_pkg::MAS_CMD_RET, pcs[0]);
    end
    r = xs();
    cmd_target = r[11:0];
    pcs[0] = epc;
    run(mas_pkg::MAS_CMD_CALL, r[11:0]);
    run(mas_pkg::MAS_CMD_RET, pcs[0]);
    $display("calls done");
    wr(8'hfc, 4'hf);
    wr(8'hfd, 4'hf);
    wr(8'hfe, 4'h0);
    eq.push_back({8'h00, img[12'h0ff][7:4]});
    run(mas_pkg::MAS_CMD_TBL_HIGH, epc);
    eq.push_back({8'h00, img[12'h100][3:0]});
    run(mas_pkg::MAS_CMD_TBL_LOW, epc);
    rd(8'hfc, 4'h0);
    rd(8'hfd, 4'h0);
    rd(8'hfe, 4'h1);
    $display("table reads done");
    for (k = 0; k < 2; k++) begin
      r = xs();
      cmd_data = 4'h3;
      run(mas_pkg::MAS_CMD_SET_PAGE, epc);
      cmd_data = 4'h5;
      run(mas_pkg::MAS_CMD_SET_WORD, epc);
      chk({4'h0, page_pointer, word_pointer}, 12'h035);
      cmd_use_imm = 1'b0;
      cmd_data = r[3:0];
      run(mas_pkg::MAS_CMD_RAM_WRITE, epc);
      chk({4'h0, ram_address_buffer}, 12'h035);
      set_val = {3'b000, k[0]};
      set_flags = 1'b1;
      eq.push_back({4'h0, img[{7'h7f, k[0], r[3:0]}]});
      run(mas_pkg::MAS_CMD_PATTERN, epc);
      set_flags = 1'b0;
      eq.push_back(12'h005);
      run(mas_pkg::MAS_CMD_PORT_BIT, epc);
      eq.push_back({8'h00, r[3:0]});
      run(mas_pkg::MAS_CMD_RAM_READ, epc);
    end
    $display("pattern and pointers done");
    cmd_valid = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(12'(pq.size() + eq.size()), 12'h000);
    results();
  end
endmodule : tb_memory_addressing_and_stack
